// ==== rxcfg_pkg.sv ====
// Constants and types for the receive configuration register bank
// ==========================================
// How it works
// - CRC-skip bit set disables receive CRC check
// - Auto skip CRC after REQA/WUPA or anticollision
// - Length field 00 four bytes, 01 seven bytes
// - Quadrature bit selects 90 degree phase clock
// - ISO-A and type 1 always use correlator
// - ISO-B select bit picks correlator or pulse
// - Stream 01/11 selectable, other streams pulse only
// - ISO-A 106k start needs clean first nibble
// - Short erroneous frame under threshold triggers suppression
// - Start time field counts quarter etu steps
// - Early subcarrier on ISO-B 106k flags soft error
// - Early subcarrier with suppression discards, restart interrupt
// - Detection length extends the start-time check
package rxcfg_pkg;
	// ==========================================
	// Register map (index, byte address is four times it)
	localparam logic [5:0] IDX_EMD = 6'h05;
	localparam logic [5:0] IDX_SST = 6'h06;
	localparam logic [5:0] IDX_AUX = 6'h0A;
	localparam logic [5:0] IDX_IRQ_ST = 6'h10;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h11;
	localparam logic [5:0] IDX_RX_STATE = 6'h12;
	localparam logic [7:0] RESET_VAL = 8'h00;
	localparam logic [7:0] AUX_WMASK = 8'hBF;
	localparam logic [7:0] EMD_WMASK = 8'hCF;
	localparam logic [7:0] SST_WMASK = 8'h1F;
	// ==========================================
	// Field positions
	localparam int AUX_NO_CRC = 7;
	localparam int AUX_ID_HI = 5;
	localparam int AUX_ID_LO = 4;
	localparam int AUX_PHASE90 = 3;
	localparam int AUX_PULSE = 2;
	localparam int AUX_N_HI = 1;
	localparam int AUX_N_LO = 0;
	localparam int EMD_EN = 7;
	localparam int EMD_RXS = 6;
	localparam int EMD_THLD_HI = 3;
	localparam int EMD_THLD_LO = 0;
	localparam int SST_HI = 4;
	localparam int IRQ_SOFT = 0;
	localparam int IRQ_RESTART = 1;
	localparam int IRQ_EMD = 2;
	localparam int IRQ_RXS = 3;
	localparam int IRQ_W = 4;
	localparam logic [1:0] ID_4BYTE = 2'b00;
	localparam logic [1:0] ID_7BYTE = 2'b01;
	localparam logic [1:0] SCF_SELECTABLE = 2'b01;
	localparam logic [1:0] SCP_SELECTABLE = 2'b11;
	// ==========================================
	// Timing: quarter etu at 106 kb/s
	localparam int CLK_PERIOD_PS = 10000;
	localparam int QETU_PS = 2359882;
	localparam int QETU_CYC = QETU_PS / CLK_PERIOD_PS;
	localparam logic [8:0] QETU_LAST = 9'(QETU_CYC - 1);
	localparam logic [5:0] CNT_MAX = 6'h3F;
	// ==========================================
	typedef enum logic [1:0] {
		PROTO_ISO_A = 2'b00,
		PROTO_ISO_B = 2'b01,
		PROTO_TYPE1 = 2'b10,
		PROTO_STREAM = 2'b11
	} proto_t;
	typedef enum logic {
		SST_IDLE = 1'b0,
		SST_RUN = 1'b1
	} sst_state_t;
endpackage

// ==== rx_frame_emd_control.sv ====
// Receive configuration, CRC skip, EMD suppression and subcarrier start timer
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module rx_frame_emd_control import rxcfg_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Receive framer context
	input wire logic [1:0] proto_mode,
	input wire logic rate_106k,
	input wire logic [1:0] stream_scf,
	input wire logic [1:0] stream_scp,
	input wire logic anticoll_mode,
	input wire logic [2:0] subcarrier_detect_length,
	// Receive framer events
	input wire logic reqa_wupa_sent,
	input wire logic rx_first4_done,
	input wire logic rx_first4_err,
	input wire logic rx_frame_end,
	input wire logic rx_error,
	input wire logic [8:0] rx_byte_count,
	input wire logic mask_receive_timer_done,
	input wire logic subcarrier_detect,
	// Controls to the receiver
	output logic crc_check_en,
	output logic correlator_sel,
	output logic id_7byte,
	output logic phase_clock_quadrature,
	output logic [1:0] field_on_n,
	output logic rx_start,
	output logic emd_suppress,
	output logic frame_discard,
	output logic irq
);
	// ==========================================
	// Register bank and APB
	logic [7:0] aux_reg, aux_next, emd_reg, emd_next, sst_reg, sst_next;
	logic [IRQ_W-1:0] st_reg, st_next, mask_reg, mask_next, ev;
	logic [31:0] prdata_next;
	logic pready_next, pslverr_next, wr, hit;
	logic skip_reg, skip_next;
	sst_state_t tstate_reg, tstate_next;
	logic [5:0] qcnt_reg, qcnt_next;
	logic [8:0] div_reg, div_next;
	logic early;
	logic crc_next, corr_next, rxs_next, emd_sup_next, discard_next;

	always_comb begin
		wr = psel && penable && pready && pwrite;
		hit = paddr[1:0] == 2'b00 && (paddr[7:2] == IDX_AUX || paddr[7:2] == IDX_EMD
			|| paddr[7:2] == IDX_SST || paddr[7:2] == IDX_IRQ_ST
			|| paddr[7:2] == IDX_IRQ_MASK || paddr[7:2] == IDX_RX_STATE);
		aux_next = aux_reg;
		emd_next = emd_reg;
		sst_next = sst_reg;
		mask_next = mask_reg;
		// Reserved bits are masked so they never store
		if (wr && hit && paddr[7:2] == IDX_AUX) begin
			aux_next = pwdata[7:0] & AUX_WMASK;
		end
		if (wr && hit && paddr[7:2] == IDX_EMD) begin
			emd_next = pwdata[7:0] & EMD_WMASK;
		end
		if (wr && hit && paddr[7:2] == IDX_SST) begin
			sst_next = pwdata[7:0] & SST_WMASK;
		end
		if (wr && hit && paddr[7:2] == IDX_IRQ_MASK) begin
			mask_next = pwdata[IRQ_W-1:0];
		end
		// Hardware set wins over a write-one clear in the same cycle
		st_next = st_reg;
		if (wr && hit && paddr[7:2] == IDX_IRQ_ST) begin
			st_next = st_reg & ~pwdata[IRQ_W-1:0];
		end
		st_next = st_next | ev;
		// One wait state: the access phase completes on its second edge
		pready_next = psel && penable && !pready;
		pslverr_next = pready_next && !hit;
		prdata_next = 32'h0000_0000;
		if (pready_next && hit) begin
			unique case (paddr[7:2])
				IDX_AUX: prdata_next = {24'h00_0000, aux_reg};
				IDX_EMD: prdata_next = {24'h00_0000, emd_reg};
				IDX_SST: prdata_next = {24'h00_0000, sst_reg};
				IDX_IRQ_ST: prdata_next = {28'h000_0000, st_reg};
				IDX_IRQ_MASK: prdata_next = {28'h000_0000, mask_reg};
				default: prdata_next = {22'h00_0000, qcnt_reg, tstate_reg, skip_reg,
					correlator_sel, crc_check_en};
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			aux_reg <= RESET_VAL;
			emd_reg <= RESET_VAL;
			sst_reg <= RESET_VAL;
			st_reg <= '0;
			mask_reg <= '0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
		end else begin
			aux_reg <= aux_next;
			emd_reg <= emd_next;
			sst_reg <= sst_next;
			st_reg <= st_next;
			mask_reg <= mask_next;
			prdata <= prdata_next;
			pready <= pready_next;
			pslverr <= pslverr_next;
			irq <= |(st_next & mask_next);
		end
	end

	// ==========================================
	// Reception control
	always_comb begin
		// A new REQA/WUPA overrides the end of the previous frame
		skip_next = reqa_wupa_sent ? 1'b1 : (rx_frame_end ? 1'b0 : skip_reg);
		crc_next = !aux_reg[AUX_NO_CRC] && !skip_reg && !anticoll_mode;
		unique case (proto_t'(proto_mode))
			PROTO_ISO_A, PROTO_TYPE1: corr_next = 1'b1;
			PROTO_ISO_B: corr_next = !aux_reg[AUX_PULSE];
			PROTO_STREAM: corr_next = stream_scf == SCF_SELECTABLE
				&& stream_scp == SCP_SELECTABLE && !aux_reg[AUX_PULSE];
		endcase
		// Start indication drops a dirty first nibble only on ISO-A 106k
		rxs_next = rx_first4_done && (!rx_first4_err || emd_reg[EMD_RXS]
			|| proto_t'(proto_mode) != PROTO_ISO_A || !rate_106k);
		emd_sup_next = emd_reg[EMD_EN] && rx_frame_end && rx_error
			&& rx_byte_count < 9'(emd_reg[EMD_THLD_HI:EMD_THLD_LO]);
		discard_next = early && emd_reg[EMD_EN];
		ev = '0;
		ev[IRQ_SOFT] = early && !emd_reg[EMD_EN];
		ev[IRQ_RESTART] = discard_next;
		ev[IRQ_EMD] = emd_sup_next;
		ev[IRQ_RXS] = rxs_next;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			skip_reg <= 1'b0;
			crc_check_en <= 1'b1;
			correlator_sel <= 1'b1;
			id_7byte <= 1'b0;
			phase_clock_quadrature <= 1'b0;
			field_on_n <= 2'b00;
			rx_start <= 1'b0;
			emd_suppress <= 1'b0;
			frame_discard <= 1'b0;
		end else begin
			skip_reg <= skip_next;
			crc_check_en <= crc_next;
			correlator_sel <= corr_next;
			id_7byte <= aux_reg[AUX_ID_HI:AUX_ID_LO] == ID_7BYTE;
			phase_clock_quadrature <= aux_reg[AUX_PHASE90];
			field_on_n <= aux_reg[AUX_N_HI:AUX_N_LO];
			rx_start <= rxs_next;
			emd_suppress <= emd_sup_next;
			frame_discard <= discard_next;
		end
	end

	// ==========================================
	// Subcarrier start timer, counts quarter etu after the mask timer ends
	always_comb begin
		tstate_next = tstate_reg;
		qcnt_next = qcnt_reg;
		div_next = div_reg;
		// The detector reports late by its own length, so that is added back
		early = tstate_reg == SST_RUN && subcarrier_detect && proto_t'(proto_mode) == PROTO_ISO_B
			&& rate_106k && 7'(qcnt_reg) < 7'(sst_reg[SST_HI:0]) + 7'(subcarrier_detect_length);
		unique case (tstate_reg)
			SST_IDLE: begin
				if (mask_receive_timer_done) begin
					tstate_next = SST_RUN;
					qcnt_next = 6'h00;
					div_next = 9'h000;
				end
			end
			SST_RUN: begin
				div_next = div_reg == QETU_LAST ? 9'h000 : div_reg + 9'h001;
				if (div_reg == QETU_LAST && qcnt_reg != CNT_MAX) begin
					qcnt_next = qcnt_reg + 6'h01;
				end
				if (subcarrier_detect || rx_frame_end) begin
					tstate_next = SST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tstate_reg <= SST_IDLE;
			qcnt_reg <= 6'h00;
			div_reg <= 9'h000;
		end else begin
			tstate_reg <= tstate_next;
			qcnt_reg <= qcnt_next;
			div_reg <= div_next;
		end
	end

	// ==========================================
	// Checks
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	crc_skip_a: assert property (aux_reg[AUX_NO_CRC] |=> !crc_check_en)
		else $error("CRC check active with skip bit set");
	auto_skip_a: assert property (reqa_wupa_sent ##1 !rx_frame_end |=> !crc_check_en)
		else $error("CRC not skipped after REQA or WUPA");
	id_len_a: assert property (aux_reg[AUX_ID_HI:AUX_ID_LO] == ID_4BYTE |=> !id_7byte)
		else $error("Seven byte id with length field zero");
	phase_clk_a: assert property ($rose(aux_reg[AUX_PHASE90]) |=> phase_clock_quadrature)
		else $error("Quadrature clock not selected");
	corr_fixed_a: assert property (proto_mode == PROTO_ISO_A || proto_mode == PROTO_TYPE1
		|=> correlator_sel)
		else $error("Pulse reception on ISO-A or type 1");
	pulse_sel_a: assert property (proto_mode == PROTO_ISO_B && aux_reg[AUX_PULSE]
		|=> !correlator_sel)
		else $error("ISO-B pulse select ignored");
	rx_start_a: assert property (rx_first4_done && rx_first4_err && proto_mode == PROTO_ISO_A
		&& rate_106k && !emd_reg[EMD_RXS] |=> !rx_start)
		else $error("Start signalled on dirty first nibble");
	emd_trig_a: assert property (emd_reg[EMD_EN] && rx_frame_end && rx_error && rx_byte_count[8:4] == 5'h00
		&& rx_byte_count[3:0] < emd_reg[EMD_THLD_HI:EMD_THLD_LO] |=> emd_suppress && st_reg[IRQ_EMD])
		else $error("EMD suppression missed");
	early_soft_a: assert property (early && !emd_reg[EMD_EN] |=> st_reg[IRQ_SOFT] && !frame_discard)
		else $error("Early subcarrier soft error missed");
	early_emd_a: assert property (early && emd_reg[EMD_EN] |=> frame_discard && st_reg[IRQ_RESTART])
		else $error("Early subcarrier not discarded");

	// CRC check enable, and the auto skip flag following REQA/WUPA and frame end
	anticoll_skip_a: assert property (anticoll_mode |=> !crc_check_en)
		else $error("CRC check active during anticollision");
	crc_on_a: assert property (!aux_reg[AUX_NO_CRC] && !skip_reg && !anticoll_mode |=> crc_check_en)
		else $error("CRC check dropped without a reason");
	skip_hold_a: assert property (skip_reg && !reqa_wupa_sent && !rx_frame_end |=> skip_reg)
		else $error("Auto skip flag lost before frame end");
	skip_end_a: assert property (rx_frame_end && !reqa_wupa_sent |=> !skip_reg)
		else $error("Auto skip flag kept after frame end");
	// Configuration outputs follow the auxiliary register
	id_seven_a: assert property (aux_reg[AUX_ID_HI:AUX_ID_LO] == ID_7BYTE |=> id_7byte)
		else $error("Seven byte id not selected");
	id_reserved_a: assert property (aux_reg[AUX_ID_HI] |=> !id_7byte)
		else $error("Reserved id length selects seven bytes");
	phase_low_a: assert property (!aux_reg[AUX_PHASE90] |=> !phase_clock_quadrature)
		else $error("Quadrature clock selected with bit clear");
	corr_iso_b_a: assert property (proto_mode == PROTO_ISO_B && !aux_reg[AUX_PULSE] |=> correlator_sel)
		else $error("ISO-B correlator select ignored");
	stream_pulse_a: assert property (proto_mode == PROTO_STREAM
		&& !(stream_scf == SCF_SELECTABLE && stream_scp == SCP_SELECTABLE) |=> !correlator_sel)
		else $error("Correlator used in a pulse-only stream mode");
	stream_corr_a: assert property (proto_mode == PROTO_STREAM && stream_scf == SCF_SELECTABLE
		&& stream_scp == SCP_SELECTABLE && !aux_reg[AUX_PULSE] |=> correlator_sel)
		else $error("Stream correlator select ignored");
	// Reception start indication
	start_clean_a: assert property (rx_first4_done && !rx_first4_err |=> rx_start)
		else $error("Start missing after a clean first nibble");
	start_forced_a: assert property (rx_first4_done && emd_reg[EMD_RXS] |=> rx_start)
		else $error("Start missing with the start control bit set");
	start_idle_a: assert property (!rx_first4_done |=> !rx_start)
		else $error("Start signalled without a first nibble");
	stat_rxs_a: assert property (rx_first4_done && !rx_first4_err |=> st_reg[IRQ_RXS])
		else $error("Start status bit not set");
	// Suppression and discard need the enable bit
	emd_off_a: assert property (!emd_reg[EMD_EN] |=> !emd_suppress && !frame_discard)
		else $error("Suppression or discard while disabled");
	emd_long_a: assert property (rx_byte_count[8:4] != 5'h00 |=> !emd_suppress)
		else $error("Suppression on a frame above any threshold");
	late_keep_a: assert property (!early |=> !frame_discard)
		else $error("Frame discarded without an early subcarrier");
	// Start timer counting
	timer_start_a: assert property (tstate_reg == SST_IDLE && mask_receive_timer_done
		|=> tstate_reg == SST_RUN && qcnt_reg == 6'h00)
		else $error("Start timer did not restart at mask timer expiry");
	timer_hold_a: assert property (tstate_reg == SST_RUN && div_reg != QETU_LAST
		|=> qcnt_reg == $past(qcnt_reg))
		else $error("Quarter etu count moved inside a step");
	timer_step_a: assert property (tstate_reg == SST_RUN && div_reg == QETU_LAST && qcnt_reg != CNT_MAX
		|=> qcnt_reg == $past(qcnt_reg) + 6'h01)
		else $error("Quarter etu count missed a step");
	timer_stop_a: assert property (tstate_reg == SST_RUN && subcarrier_detect |=> tstate_reg == SST_IDLE)
		else $error("Start timer still running after detection");
	// Register side
	irq_level_a: assert property (irq == |(st_reg & mask_reg))
		else $error("Interrupt line disagrees with status and mask");
	rsvd_zero_a: assert property ((aux_reg & ~AUX_WMASK) == 8'h00 && (emd_reg & ~EMD_WMASK) == 8'h00
		&& (sst_reg & ~SST_WMASK) == 8'h00)
		else $error("Reserved bit stored");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("Slave error outside a completed transfer");
endmodule

// ==== card_model.sv ====
// Card-side model: drives the receive framer events a tag would cause
`timescale 1ns/1ps
module card_model (
	// Clock
	input wire logic mclk,
	// Framer events
	output logic rx_first4_done,
	output logic rx_first4_err,
	output logic rx_frame_end,
	output logic rx_error,
	output logic [8:0] rx_byte_count,
	output logic subcarrier_detect
);
	initial begin
		{rx_first4_done, rx_frame_end, subcarrier_detect} = 3'h0;
		{rx_first4_err, rx_error, rx_byte_count} = 11'h7FF;
	end
	// ==========================================
	// Qualifiers are inverted after use so a stale value never passes as fresh
	task automatic first4(input logic err);
		rx_first4_done <= 1'b1;
		rx_first4_err <= err;
		@(posedge mclk);
		rx_first4_done <= 1'b0;
		rx_first4_err <= ~err;
		@(posedge mclk);
	endtask
	task automatic frame(input logic err, input logic [8:0] cnt);
		rx_frame_end <= 1'b1;
		rx_error <= err;
		rx_byte_count <= cnt;
		@(posedge mclk);
		rx_frame_end <= 1'b0;
		rx_error <= ~err;
		rx_byte_count <= ~cnt;
		@(posedge mclk);
	endtask
	task automatic sc();
		subcarrier_detect <= 1'b1;
		@(posedge mclk);
		subcarrier_detect <= 1'b0;
	endtask
endmodule

// ==== rx_frame_emd_control_tb.sv ====
// Self-checking bench for the receive configuration register bank
`timescale 1ns/1ps
module rx_frame_emd_control_tb;
	import rxcfg_pkg::*;
	// ==========================================
	// Signals
	logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [1:0] proto_mode = 2'h0, stream_scf = 2'h0, stream_scp = 2'h0;
	logic rate_106k = 1'b1, anticoll_mode = 1'b0, reqa = 1'b0, mask_receive_timer = 1'b0;
	logic [2:0] det_len = 3'h0;
	logic [31:0] prdata;
	logic [8:0] rx_byte_count;
	logic [1:0] field_on_n;
	logic pready, pslverr, crc_check_en, correlator_sel, id_7byte, phase_clock_quadrature;
	logic rx_start, emd_suppress, frame_discard, irq;
	logic rx_first4_done, rx_first4_err, rx_frame_end, rx_error, subcarrier_detect;
	int n_errors = 0, checked = 0, cyc = 0, n_rxs = 0, n_emd = 0, n_disc = 0;
	card_model card_u (.mclk, .rx_first4_done, .rx_first4_err, .rx_frame_end, .rx_error, .rx_byte_count,
		.subcarrier_detect);
	rx_frame_emd_control dut_u (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .proto_mode, .rate_106k, .stream_scf, .stream_scp, .anticoll_mode,
		.subcarrier_detect_length(det_len), .reqa_wupa_sent(reqa), .rx_first4_done, .rx_first4_err,
		.rx_frame_end, .rx_error, .rx_byte_count, .mask_receive_timer_done(mask_receive_timer), .subcarrier_detect,
		.crc_check_en, .correlator_sel, .id_7byte, .phase_clock_quadrature, .field_on_n, .rx_start,
		.emd_suppress, .frame_discard, .irq);
	always #5 mclk = ~mclk;
	// ==========================================
	// Pulse counters and hang guard; the run needs about 1200 cycles
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		n_rxs <= n_rxs + (rx_start === 1'b1);
		n_emd <= n_emd + (emd_suppress === 1'b1);
		n_disc <= n_disc + (frame_discard === 1'b1);
		if (cyc == 20000) begin
			n_errors++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// ==========================================
	// APB master: request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d,
		output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge so a following call never rewrites psel in this time step
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] d;
		logic e;
		apb(1'b1, a, v, d, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic e;
		apb(1'b0, a, 32'h0, d, e);
		chk($sformatf("reg %h", a), d, exp);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_regs();
		logic [31:0] d;
		logic e;
		rd(8'h14, 32'h0);
		rd(8'h18, 32'h0);
		rd(8'h28, 32'h0);
		chk("crc_check_en", crc_check_en, 1);
		wr(8'h28, 32'hFF);
		rd(8'h28, 32'hBF);
		wr(8'h14, 32'hFF);
		rd(8'h14, 32'hCF);
		wr(8'h18, 32'hFF);
		rd(8'h18, 32'h1F);
		wt(2);
		chk("crc_check_en", crc_check_en, 0);
		chk("id_7byte", id_7byte, 0);
		chk("quadrature", phase_clock_quadrature, 1);
		chk("field_on_n", field_on_n, 3);
		wr(8'h28, 32'h10);
		wr(8'h14, 32'h0);
		wt(2);
		chk("id_7byte", id_7byte, 1);
		chk("quadrature", phase_clock_quadrature, 0);
		apb(1'b0, 8'h3C, 32'h0, d, e);
		chk("pslverr", e, 1);
	endtask
	task automatic corr(input logic [1:0] pm, input logic [1:0] f, input logic [1:0] p, input logic exp);
		proto_mode <= pm;
		stream_scf <= f;
		stream_scp <= p;
		wt(3);
		chk("correlator_sel", correlator_sel, exp);
	endtask
	task automatic t_corr();
		wr(8'h28, 32'h04);
		corr(2'h0, 2'h0, 2'h0, 1);
		corr(2'h2, 2'h0, 2'h0, 1);
		corr(2'h1, 2'h0, 2'h0, 0);
		corr(2'h3, 2'h1, 2'h3, 0);
		wr(8'h28, 32'h00);
		corr(2'h3, 2'h1, 2'h3, 1);
		corr(2'h3, 2'h0, 2'h3, 0);
		corr(2'h1, 2'h0, 2'h0, 1);
		corr(2'h0, 2'h0, 2'h0, 1);
	endtask
	task automatic t_skip();
		reqa <= 1'b1;
		wt(1);
		reqa <= 1'b0;
		wt(3);
		chk("crc_check_en", crc_check_en, 0);
		card_u.frame(1'b0, 9'h005);
		wt(3);
		chk("crc_check_en", crc_check_en, 1);
		anticoll_mode <= 1'b1;
		wt(3);
		chk("crc_check_en", crc_check_en, 0);
		anticoll_mode <= 1'b0;
		wt(3);
		chk("crc_check_en", crc_check_en, 1);
	endtask
	task automatic t_rxs_emd();
		int b = n_rxs;
		int m = n_emd;
		card_u.first4(1'b1);
		wt(2);
		chk("rx_start count", n_rxs - b, 0);
		wr(8'h14, 32'h40);
		card_u.first4(1'b1);
		card_u.first4(1'b0);
		wt(2);
		chk("rx_start count", n_rxs - b, 2);
		wr(8'h14, 32'h84);
		card_u.frame(1'b1, 9'h003);
		card_u.frame(1'b1, 9'h004);
		card_u.frame(1'b0, 9'h002);
		wr(8'h14, 32'h04);
		card_u.frame(1'b1, 9'h003);
		wt(2);
		chk("emd_suppress count", n_emd - m, 1);
		rd(8'h40, 32'hC);
		wr(8'h40, 32'hF);
	endtask
	task automatic early(input logic [4:0] s, input logic [2:0] l, input int g, input logic [3:0] st,
		input logic iq);
		wr(8'h18, {27'h0, s});
		det_len <= l;
		mask_receive_timer <= 1'b1;
		wt(1);
		mask_receive_timer <= 1'b0;
		wt(g);
		card_u.sc();
		wt(2);
		chk("irq", irq, iq);
		rd(8'h40, {28'h0, st});
		wr(8'h40, 32'hF);
		wt(2);
		chk("irq", irq, 0);
	endtask
	task automatic t_sst();
		int b = n_disc;
		proto_mode <= 2'h1;
		wr(8'h14, 32'h00);
		wr(8'h44, 32'h3);
		early(5'h04, 3'h0, 10, 4'h1, 1);
		early(5'h01, 3'h0, 600, 4'h0, 0);
		early(5'h01, 3'h2, 300, 4'h1, 1);
		wr(8'h14, 32'h80);
		early(5'h04, 3'h0, 10, 4'h2, 1);
		chk("frame_discard count", n_disc - b, 1);
		wr(8'h44, 32'h0);
		early(5'h04, 3'h0, 10, 4'h2, 0);
	endtask
	initial begin
		wt(20);
		rst_n <= 1'b1;
		t_regs();
		t_corr();
		t_skip();
		t_rxs_emd();
		t_sst();
		end_of_test();
	end
endmodule
